/* File: rtl/pao_core.sv */
/*
  pao_core: digital side of a 12-bit pipelined sampling converter.
  Assumes the conversion start arrives as a synchronous level on i_conv_clk,
  sampled on i_clk; the analog core delivers a raw two's-complement code on
  i_raw_code at each start. Straps are static after reset.
*/
// Function
// - each rising edge of the conversion clock samples both inputs at once and, when no conversion is running, starts one.
// - a sample's result reaches the outputs two further starts plus a conversion time later.
// - results are 12-bit two's complement, msb on the highest output bit.
// - the out-of-range flag is high exactly for codes 7FF and 800.
// - after 500 us with no conversion edge an internal timer refreshes the dynamic logic.
// - gain select high gives unity gain, low gives gain two.
// - the reference strap picks 4.096 V, 2.048 V or an external reference.
// - only the rising conversion edge times the internal operation.
// - a started conversion always completes and cannot be aborted.
`timescale 1ns/1ps
module pao_core
  import pao_pkg::*;
#(
  parameter int IDLE_CYC = PAO_IDLE_CYC
)(
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  // conversion start and analog core result
  input  wire logic              i_conv_clk,
  input  wire logic [11:0]       i_raw_code,
  // straps
  input  wire logic              i_gain_sel,
  input  wire logic [1:0]        i_ref_strap,
  // parallel result
  output logic      [11:0]       o_result_word_bits,
  output logic                   o_out_of_range_flag,
  // analog core controls
  output logic                   o_sample_hold,
  output logic                   o_pga_gain_two,
  output logic      [1:0]        o_ref_sel,
  output logic                   o_ref_amp_off,
  output logic                   o_refresh
);

  // elaboration-time refusal: a timeout under two cycles would refresh back to back
  if (IDLE_CYC < 2)
  begin
    $error("IDLE_CYC too small");
  end

  localparam int CW      = $clog2(IDLE_CYC + 1);
  localparam int PW      = $clog2(PAO_CONV_CYC + 1);
  localparam int RES_DLY = PAO_CONV_CYC + 1;  // launching start to settled result

  // out-of-range decode, used for the output flag only
  function automatic logic f_oor(input logic [11:0] c);
    f_oor = (c == PAO_CODE_MAXPOS) || (c == PAO_CODE_MAXNEG);
  endfunction

  typedef enum logic [0:0] {
    PAO_IDLE = 1'b0,
    PAO_CONV = 1'b1
  } pao_st_t;

  logic           clk_prev_q,  clk_prev_d;
  logic [11:0]    stage_q [0:1];
  logic [11:0]    stage_d [0:1];
  logic [11:0]    conv_code_q, conv_code_d;
  pao_st_t        st_q,        st_d;
  logic [PW-1:0]  conv_cnt_q,  conv_cnt_d;
  logic [CW-1:0]  idle_cnt_q,  idle_cnt_d;
  logic [11:0]    res_q,       res_d;
  logic           oor_q,       oor_d;
  logic           sh_q,        sh_d;
  logic           refresh_q,   refresh_d;
  logic           gain2_q,     gain2_d;
  logic [1:0]     ref_q,       ref_d;
  logic           refoff_q,    refoff_d;
  logic           start;

  // only the rising edge counts; duty cycle is irrelevant
  assign start = i_conv_clk & ~clk_prev_q;

  // pipeline, conversion timer, idle refresh timer
  always_comb
  begin
    clk_prev_d  = i_conv_clk;
    stage_d[0]  = stage_q[0];
    stage_d[1]  = stage_q[1];
    conv_code_d = conv_code_q;
    st_d        = st_q;
    conv_cnt_d  = conv_cnt_q;
    idle_cnt_d  = idle_cnt_q;
    res_d       = res_q;
    oor_d       = oor_q;
    sh_d        = start;
    refresh_d   = 1'b0;
    if (start)
    begin
      stage_d[0] = i_raw_code;               // both inputs sampled together
      stage_d[1] = stage_q[0];
      idle_cnt_d = '0;
    end
    else if (idle_cnt_q == CW'(IDLE_CYC - 1))
    begin
      // periodic refresh keeps dynamic nodes alive while the clock is stopped
      refresh_d  = 1'b1;
      idle_cnt_d = '0;
    end
    else
    begin
      idle_cnt_d = idle_cnt_q + CW'(1);
    end
    case (st_q)
      PAO_IDLE:
      begin
        if (start)
        begin
          // oldest sample finishes after two further starts
          conv_code_d = stage_q[1];
          conv_cnt_d  = PW'(PAO_CONV_CYC - 1);
          st_d        = PAO_CONV;
        end
      end
      PAO_CONV:
      begin
        // a running conversion ignores new starts until done
        if (conv_cnt_q == '0)
        begin
          res_d = conv_code_d;
          oor_d = f_oor(conv_code_d);
          st_d  = PAO_IDLE;
        end
        else
          conv_cnt_d = conv_cnt_q - PW'(1);
      end
      default: st_d = PAO_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      clk_prev_q  <= 1'b0;
      stage_q[0]  <= PAO_RESULT_RST;
      stage_q[1]  <= PAO_RESULT_RST;
      conv_code_q <= PAO_RESULT_RST;
      st_q        <= PAO_IDLE;
      conv_cnt_q  <= '0;
      idle_cnt_q  <= '0;
      res_q       <= PAO_RESULT_RST;
      oor_q       <= 1'b0;
      sh_q        <= 1'b0;
      refresh_q   <= 1'b0;
    end
    else
    begin
      clk_prev_q  <= clk_prev_d;
      stage_q[0]  <= stage_d[0];
      stage_q[1]  <= stage_d[1];
      conv_code_q <= conv_code_d;
      st_q        <= st_d;
      conv_cnt_q  <= conv_cnt_d;
      idle_cnt_q  <= idle_cnt_d;
      res_q       <= res_d;
      oor_q       <= oor_d;
      sh_q        <= sh_d;
      refresh_q   <= refresh_d;
    end
  end

  // strap decode for gain and reference
  always_comb
  begin
    gain2_d  = ~i_gain_sel;
    ref_d    = i_ref_strap;
    refoff_d = (pao_ref_t'(i_ref_strap) == PAO_REF_EXT);
  end

  // straps are sampled by a clocked stage, never by the reset itself
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      gain2_q  <= 1'b0;
      ref_q    <= 2'b00;
      refoff_q <= 1'b0;
    end
    else
    begin
      gain2_q  <= gain2_d;
      ref_q    <= ref_d;
      refoff_q <= refoff_d;
    end
  end

  assign o_result_word_bits  = res_q;
  assign o_out_of_range_flag = oor_q;
  assign o_sample_hold       = sh_q;
  assign o_pga_gain_two      = gain2_q;
  assign o_ref_sel           = ref_q;
  assign o_ref_amp_off       = refoff_q;
  assign o_refresh           = refresh_q;

  // checks; the flag is held against the two limit codes, not against the decode function
  a_flag_matches: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_out_of_range_flag == ((o_result_word_bits == PAO_CODE_MAXPOS) ||
                            (o_result_word_bits == PAO_CODE_MAXNEG)))
    else $error("flag disagrees with word");
  a_sample_pulse: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_conv_clk && !clk_prev_q) |=> o_sample_hold)
    else $error("start not sampled");
  a_no_double_start: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_sample_hold |=> !o_sample_hold)
    else $error("start on level not edge");
  a_result_timing: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (st_q == PAO_IDLE && start) |->
      ##RES_DLY (res_q == $past(stage_q[1], RES_DLY)))
    else $error("result late or wrong");
  // eight busy cycles: the package conversion count at its 70 ns / 8 ns value
  a_conv_completes: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (st_q == PAO_IDLE && start) |=> (st_q == PAO_CONV)[*8] ##1 st_q == PAO_IDLE)
    else $error("conversion aborted");
  a_refresh_idle: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_refresh |-> $past(idle_cnt_q) == CW'(IDLE_CYC - 1))
    else $error("refresh at wrong time");
  a_gain_map: assert property (@(posedge i_clk) disable iff (!i_resetn)
    ##1 o_pga_gain_two == !$past(i_gain_sel))
    else $error("gain mapping wrong");
  a_ref_ext: assert property (@(posedge i_clk) disable iff (!i_resetn)
    ##1 o_ref_amp_off == ($past(i_ref_strap) == PAO_REF_EXT))
    else $error("reference amp control wrong");
  c_start: cover property (@(posedge i_clk) disable iff (!i_resetn) start);
  c_oor: cover property (@(posedge i_clk) disable iff (!i_resetn) o_out_of_range_flag);
  c_refresh: cover property (@(posedge i_clk) disable iff (!i_resetn) o_refresh);
  c_conv_done: cover property (@(posedge i_clk) disable iff (!i_resetn)
    st_q == PAO_CONV ##1 st_q == PAO_IDLE);
endmodule

/* File: rtl/pao_pkg.sv */
/*
  pao_pkg: constants for the pipelined converter sample output block.
  Assumes a single 125 MHz system clock; no software registers.
*/
package pao_pkg;
  localparam int          PAO_DATA_W      = 12;
  localparam int          PAO_LATENCY     = 3;    // sampling edge to latch edge
  localparam int          PAO_CLK_NS      = 8;
  localparam int          PAO_CONV_NS     = 70;   // conversion time
  // conversion time in clocks, rounded down, at least one
  localparam int          PAO_CONV_CYC    = (PAO_CONV_NS / PAO_CLK_NS) < 1 ? 1
                                            : (PAO_CONV_NS / PAO_CLK_NS);
  localparam int          PAO_IDLE_US     = 500;  // refresh timeout
  localparam int          PAO_IDLE_CYC    = PAO_IDLE_US * 1000 / PAO_CLK_NS;
  localparam logic [11:0] PAO_CODE_MAXPOS = 12'h7FF;
  localparam logic [11:0] PAO_CODE_MAXNEG = 12'h800;
  localparam logic [11:0] PAO_RESULT_RST  = 12'h000;

  // reference strap selection
  typedef enum logic [1:0] {
    PAO_REF_4V096 = 2'b00,
    PAO_REF_2V048 = 2'b01,
    PAO_REF_EXT   = 2'b10,
    PAO_REF_RSVD  = 2'b11
  } pao_ref_t;
endpackage

/* File: test/pao_host_model.sv */
/* pao_host_model: host logic that clocks the converter and latches its results.
   assumes the design shares i_clk and reset; i_high sets the clock's high time. */
`timescale 1ns/1ps
module pao_host_model
  import pao_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // run control
  input  wire logic        i_run,
  input  wire logic [3:0]  i_high,
  // converter outputs
  input  wire logic [11:0] i_word,
  input  wire logic        i_flag,
  // conversion clock and captures
  output logic             o_conv_clk,
  output logic [7:0]       o_cnt,
  output logic [11:0]      o_cap_word,
  output logic             o_cap_flag,
  output logic [11:0]      o_offset_bin
);
  logic [3:0] ph_q;
  logic       prev_q;

  // 12-cycle period keeps held stage values fresh; clock stands low when stopped
  always @(negedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ph_q       <= 4'h0;
      o_conv_clk <= 1'b0;
    end
    else
    begin
      ph_q       <= (!i_run || ph_q == 4'hB) ? 4'h0 : ph_q + 4'h1;
      o_conv_clk <= i_run && (ph_q < i_high);
    end
  end

  // word and flag latched together on the start edge, three starts after sampling
  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      prev_q     <= 1'b0;
      o_cnt      <= 8'h00;
      o_cap_word <= 12'h000;
      o_cap_flag <= 1'b0;
    end
    else
    begin
      prev_q <= o_conv_clk;
      if (o_conv_clk && !prev_q)
      begin
        o_cnt      <= o_cnt + 8'h01;
        o_cap_word <= i_word;
        o_cap_flag <= i_flag;
      end
    end
  end

  // straight binary needs only the top bit turned over
  assign o_offset_bin = {~o_cap_word[11], o_cap_word[10:0]};
endmodule

/* File: test/tb_pipelined_adc_sample_output.sv */
/* tb_pipelined_adc_sample_output: self-checking bench for pao_core.
   assumes pao_host_model clocks the converter; refresh timeout shortened to 20. */
`timescale 1ns/1ps
module tb_pipelined_adc_sample_output;
  import pao_pkg::*;
  logic        i_clk = 0, i_resetn = 0, run = 0, gain = 1, conv, sh, rf, g2, aoff, flag, cflag;
  logic [1:0]  strap = 2'h0, rsel;
  logic [3:0]  high = 4'h6;
  logic [7:0]  cnt;
  logic [11:0] raw, word, cword, offs, e;
  logic [11:0] tbl [8] = '{12'h7FF, 12'h800, 12'h7FE, 12'h801, 12'h000, 12'hFFF, 12'h555, 12'hAAA};
  int          errors = 0, compares = 0, shn = 0, n;

  always #4 i_clk = ~i_clk;
  assign raw = tbl[cnt[2:0]];
  // sample pulses counted so each start can be matched to one
  always @(posedge i_clk) if (sh === 1'b1) shn++;

  pao_core #(.IDLE_CYC(20)) u_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_conv_clk(conv),
    .i_raw_code(raw), .i_gain_sel(gain), .i_ref_strap(strap), .o_result_word_bits(word),
    .o_out_of_range_flag(flag), .o_sample_hold(sh), .o_pga_gain_two(g2), .o_ref_sel(rsel),
    .o_ref_amp_off(aoff), .o_refresh(rf));
  pao_host_model u_host (.i_clk(i_clk), .i_resetn(i_resetn), .i_run(run), .i_high(high),
    .i_word(word), .i_flag(flag), .o_conv_clk(conv), .o_cnt(cnt), .o_cap_word(cword),
    .o_cap_flag(cflag), .o_offset_bin(offs));

  task automatic wrap_up();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  task automatic rst();
    resetn_low: begin i_resetn = 0; run = 0; end
    repeat (6) @(negedge i_clk);
    i_resetn = 1;
    @(negedge i_clk);
    shn = 0;
  endtask

  // sixteen starts; from the fourth start on, each capture must hold the code sampled three starts earlier
  task automatic run_seq(input logic [3:0] hi);
    rst();
    high = hi;
    run = 1;
    for (int k = 1; k <= 16; k++)
    begin
      n = 0;
      while (cnt !== 8'(k) && n < 30)
      begin
        @(negedge i_clk);
        n++;
      end
      if (cnt !== 8'(k))
      begin
        chk(0, "start timeout");
        wrap_up();
      end
      if (k >= 4)
      begin
        e = tbl[(k - 4) % 8];
        chk(cword === e, "result word");
        chk(cflag === (e == 12'h7FF || e == 12'h800), "range flag");
        chk(offs === e + 12'h800, "offset binary");
      end
    end
    // the pulse for the last start is counted one clock after that start
    @(negedge i_clk);
    run = 0;
    chk(shn === 16, "sample pulses");
    $display("run_seq high=%0d done", hi);
  endtask

  // clock stopped: one refresh pulse once the shortened timeout runs out
  task automatic idle();
    n = 0;
    while (rf !== 1'b1 && n < 40)
    begin
      @(negedge i_clk);
      n++;
    end
    chk(n >= 15 && n <= 23, "refresh timing");
    @(negedge i_clk);
    chk(rf === 1'b0, "refresh width");
    $display("idle done");
  endtask

  task automatic straps();
    for (int r = 0; r < 4; r++)
      for (int g = 0; g < 2; g++)
      begin
        strap = 2'(r);
        gain = 1'(g);
        repeat (2) @(negedge i_clk);
        chk(rsel === 2'(r) && aoff === (r == 2), "reference strap");
        chk(g2 === !gain, "gain select");
      end
    $display("straps done");
  endtask

  initial
  begin
    run_seq(4'h6);
    idle();
    run_seq(4'h1);
    straps();
    wrap_up();
  end
endmodule
